/* tb/omc_key_switch.sv */
`timescale 1ns/1ps
`default_nettype none
module omc_key_switch (
  input wire logic aclk,
  input wire omc_pkg::omc_switch_type pos_req,
  output omc_pkg::omc_switch_type switch_pos
);
  import omc_pkg::*;
  // ----------------------------------------------------------------------------
  // Key
  // ----------------------------------------------------------------------------
  // The key is moved by hand, so it only ever rests in one of the three positions.
  always_ff @(posedge aclk) begin
    switch_pos <= pos_req;
  end
endmodule : omc_key_switch
`default_nettype wire

/* tb/omc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module omc_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire omc_pkg::omc_switch_type switch_pos,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire omc_pkg::omc_mode_type mode,
  input wire omc_pkg::omc_perm_type perm,
  input wire logic display_valid
);
  import omc_pkg::*;
  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Permissions are only meaningful once the switch has been resolved after reset.
  // The write is decoded one cycle after both halves are taken, so the response comes a cycle later still.
  wr_resp_a: assert property (wr_take |=> ##1 s_axi_bvalid && !s_axi_awready)
    else $error("write response late");
  rd_resp_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read response late");
  out_logic_a: assert property ($past(aresetn) |-> perm.out_logic == (mode inside {OMC_MODE_RUN, OMC_MODE_REM_RUN}))
    else $error("output permission wrong");
  exec_perm_a: assert property ($past(aresetn) |-> perm.exec_ok == (mode inside {OMC_MODE_RUN,
    OMC_MODE_REM_RUN, OMC_MODE_REM_TEST}))
    else $error("execute permission wrong");
  sched_perm_a: assert property ($past(aresetn) |-> perm.sched_ok == (mode inside {OMC_MODE_REM_PROGRAM_SWITCH_POSITION, OMC_MODE_PROGRAM_SWITCH_POSITION}))
    else $error("schedule permission wrong");
  edit_perm_a: assert property ($past(aresetn) |-> perm.edit_ok == (mode != OMC_MODE_RUN)
    && perm.download_ok == (mode != OMC_MODE_RUN))
    else $error("edit permission wrong");
  shared_data_a: assert property ($past(aresetn) |-> perm.partner_data)
    else $error("shared data not served");
  program_switch_position_pos_a: assert property (switch_pos == OMC_SW_PROGRAM_SWITCH_POSITION |=> mode == OMC_MODE_PROGRAM_SWITCH_POSITION)
    else $error("program position ignored");
  run_pos_a: assert property (switch_pos == OMC_SW_RUN |=> mode == OMC_MODE_RUN && !perm.edit_ok && !perm.fw_ok)
    else $error("run position ignored");
  remote_run_a: assert property (switch_pos == OMC_SW_REMOTE && mode == OMC_MODE_RUN |=> mode == OMC_MODE_REM_RUN)
    else $error("remote run not entered");
  display_hold_a: assert property (display_valid |=> display_valid)
    else $error("display dropped");
endmodule : omc_monitor
bind omc_mode_ctrl omc_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .switch_pos(switch_pos),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .mode(mode), .perm(perm),
  .display_valid(display_valid));
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import omc_pkg::*;
  // ----------------------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------------------
  logic aclk = 0;
  logic aresetn = 0;
  omc_switch_type pos_req = OMC_SW_RUN;
  omc_switch_type switch_pos;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, dvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, dname, rd;
  logic [7:0] outd;
  logic [3:0] rej;
  omc_mode_type mode;
  omc_perm_type perm;
  int bad_count = 0, checks = 0, cyc = 0;
  omc_key_switch key (.aclk(aclk), .pos_req(pos_req), .switch_pos(switch_pos));
  omc_mode_ctrl dut (.aclk(aclk), .aresetn(aresetn), .switch_pos(switch_pos), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mode(mode), .perm(perm), .out_drive(outd), .display_name(dname), .display_valid(dvalid));
  initial begin
    forever #25 aclk = ~aclk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // The whole run needs well under a thousand cycles; the ceiling only catches a hung handshake.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid);
    rsp = bresp; bready <= 0;
    @(posedge aclk);
  endtask : wr
  task automatic rdw(input logic [7:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
    rd = rdata; rsp = rresp; rready <= 0;
    @(posedge aclk);
  endtask : rdw
  function automatic logic [7:0] pexp(input omc_mode_type m);
    logic r, rp, rr;
    r = (m == OMC_MODE_RUN);
    rr = (m == OMC_MODE_REM_RUN);
    rp = (m == OMC_MODE_REM_PROGRAM_SWITCH_POSITION || m == OMC_MODE_PROGRAM_SWITCH_POSITION);
    return {1'h1, !r, rp, 1'h0, !r && m != OMC_MODE_PROGRAM_SWITCH_POSITION, !r, !rp, r || rr};
  endfunction : pexp
  // The firmware permission bit is masked: its value outside run is left to the designer.
  task automatic chk_mode(input omc_mode_type m, input omc_switch_type s);
    rdw(OMC_A_STATUS);
    cmp("status", {12'h000, rej, pexp(m), 2'h0, s, 1'h0, m}, rd & 32'hffff_efff);
    cmp("mode", 32'(m), 32'(mode));
  endtask : chk_mode
  task automatic set_sw(input omc_switch_type s);
    pos_req <= s;
    repeat (3) @(posedge aclk);
  endtask : set_sw
  task automatic do_reset(input omc_switch_type s);
    pos_req <= s; aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1; rej = 0;
    @(posedge aclk);
  endtask : do_reset
  initial begin
    do_reset(OMC_SW_RUN);
    chk_mode(OMC_MODE_RUN, OMC_SW_RUN);
    wr(OMC_A_MODE_REQ, 32'h0000_0002); rej = 4'h1;
    chk_mode(OMC_MODE_RUN, OMC_SW_RUN);
    wr(OMC_A_ACTION, 32'h0000_000d); rej = 4'hf;
    chk_mode(OMC_MODE_RUN, OMC_SW_RUN);
    wr(OMC_A_LOGIC_OUT, 32'h0000_005a);
    wr(OMC_A_OUT_CFG, 32'h0000_e1e1);
    rdw(OMC_A_OUTPUTS);
    cmp("outputs", 32'h0000_005a, rd);
    $display("test run position done");
    set_sw(OMC_SW_REMOTE);
    wr(OMC_A_ACTION, 32'h0000_0010); rej = 4'h0;
    chk_mode(OMC_MODE_REM_RUN, OMC_SW_REMOTE);
    for (int i = 1; i <= 3; i++) begin
      wr(OMC_A_MODE_REQ, 32'(i));
      chk_mode(omc_mode_type'(i), OMC_SW_REMOTE);
      cmp("drive", (i == 1) ? 32'h0000_005a : 32'h0000_0051, 32'(outd));
    end
    wr(OMC_A_MODE_REQ, 32'h0000_0004); rej = 4'h1;
    chk_mode(OMC_MODE_REM_PROGRAM_SWITCH_POSITION, OMC_SW_REMOTE);
    wr(OMC_A_NAME, 32'hc0de_0042);
    wr(OMC_A_ACTION, 32'h0000_0001);
    wr(OMC_A_ACTION, 32'h0000_0002);
    rdw(OMC_A_DISP);
    cmp("disp", 32'hc0de_0042, rd);
    cmp("disp_port", 32'hc0de_0042, dname);
    cmp("disp_valid", 32'h0000_0001, 32'(dvalid));
    $display("test remote position done");
    set_sw(OMC_SW_PROGRAM_SWITCH_POSITION);
    wr(OMC_A_ACTION, 32'h0000_0010); rej = 4'h0;
    wr(OMC_A_MODE_REQ, 32'h0000_0001); rej = 4'h1;
    chk_mode(OMC_MODE_PROGRAM_SWITCH_POSITION, OMC_SW_PROGRAM_SWITCH_POSITION);
    cmp("drive", 32'h0000_0051, 32'(outd));
    wr(8'h40, 32'h0000_0001);
    cmp("bresp", 32'(OMC_RESP_SLVERR), 32'(rsp));
    rdw(8'h40);
    cmp("rresp", 32'(OMC_RESP_SLVERR), 32'(rsp));
    cmp("rdata", 32'h0000_0000, rd);
    set_sw(OMC_SW_REMOTE);
    chk_mode(OMC_MODE_REM_PROGRAM_SWITCH_POSITION, OMC_SW_REMOTE);
    $display("test program position done");
    do_reset(OMC_SW_REMOTE);
    chk_mode(OMC_MODE_REM_PROGRAM_SWITCH_POSITION, OMC_SW_REMOTE);
    $display("test reset remote done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire

/* verilog/omc_mode_ctrl.sv */
// Contract
// - The mode follows a three-position key switch: run, remote and program, moved only by the operator.
// - In the run position online edits, downloads and firmware upgrades are refused.
// - Workstation requests for Remote Program, Remote Run or Remote Test are taken only in the remote position.
// - In the program position the mode is Program and every workstation mode request is rejected.
// - Outputs follow the project logic only in Run and Remote Run.
// - In Remote Test, Remote Program and Program each output goes to its configured on, off or hold state.
// - Tasks execute and messages are sent only in Run, Remote Run and Remote Test.
// - The network schedule may change only in Remote Program and Program.
// - Online editing is allowed in every mode except Run.
// - Data requests from other controllers and shared tags are served in all five modes.
// - Remote Run is Run with online editing added; the code also allows downloads and firmware upgrades there.
// - Remote Program behaves like Program, except that workstation mode requests are taken there.
// - When a download completes, the loaded project name goes to the status display.
`timescale 1ns/1ps
`default_nettype none
module omc_mode_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire omc_pkg::omc_switch_type switch_pos,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output omc_pkg::omc_mode_type mode,
  output omc_pkg::omc_perm_type perm,
  output logic [omc_pkg::OMC_NOUT-1:0] out_drive,
  output logic [omc_pkg::OMC_NAME_W-1:0] display_name,
  output logic display_valid
);
  import omc_pkg::*;

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  omc_mode_type mode_r, mode_nxt;
  omc_perm_type perm_r, perm_nxt;
  logic [OMC_NOUT-1:0] out_r, out_nxt;
  logic [2*OMC_NOUT-1:0] out_cfg_r, out_cfg_nxt;
  logic [OMC_NOUT-1:0] logic_out_r, logic_out_nxt;
  logic [OMC_NAME_W-1:0] name_r, name_nxt, disp_r, disp_nxt;
  logic disp_v_r, disp_v_nxt;
  logic dl_busy_r, dl_busy_nxt;
  logic rej_r, rej_nxt, dl_rej_r, dl_rej_nxt, ed_rej_r, ed_rej_nxt, fw_rej_r, fw_rej_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic wr_fire;
  logic [31:0] wval;
  logic wr_hit;

  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign wval = wdata_r & {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  // ----------------------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------------------
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && !aw_got_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_r) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? OMC_RESP_OKAY : OMC_RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
    end
  end

  always_comb begin
    unique case (awaddr_r)
      OMC_A_MODE_REQ, OMC_A_ACTION, OMC_A_OUT_CFG, OMC_A_LOGIC_OUT, OMC_A_NAME: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Mode machine and permissions
  // ----------------------------------------------------------------------------
  always_comb begin
    omc_mode_type req;
    logic [4:0] act;
    req = omc_mode_type'(wval[2:0]);
    act = 5'h0_0;
    if (wr_fire && awaddr_r == OMC_A_ACTION) begin
      act = wval[4:0];
    end
    mode_nxt = mode_r;
    rej_nxt = rej_r;
    dl_rej_nxt = dl_rej_r;
    ed_rej_nxt = ed_rej_r;
    fw_rej_nxt = fw_rej_r;
    dl_busy_nxt = dl_busy_r;
    disp_nxt = disp_r;
    disp_v_nxt = disp_v_r;
    out_cfg_nxt = out_cfg_r;
    logic_out_nxt = logic_out_r;
    name_nxt = name_r;
    if (act[OMC_ACT_CLR_REJ]) begin
      rej_nxt = 1'b0;
      dl_rej_nxt = 1'b0;
      ed_rej_nxt = 1'b0;
      fw_rej_nxt = 1'b0;
    end
    unique case (switch_pos)
      OMC_SW_RUN: mode_nxt = OMC_MODE_RUN;
      OMC_SW_PROGRAM_SWITCH_POSITION: mode_nxt = OMC_MODE_PROGRAM_SWITCH_POSITION;
      OMC_SW_REMOTE: begin
        if (mode_r == OMC_MODE_RUN || mode_r == OMC_MODE_PROGRAM_SWITCH_POSITION) begin
          mode_nxt = mode_r == OMC_MODE_RUN ? OMC_MODE_REM_RUN : OMC_MODE_REM_PROGRAM_SWITCH_POSITION;
        end
      end
      default: mode_nxt = mode_r;
    endcase
    if (wr_fire && awaddr_r == OMC_A_MODE_REQ) begin
      // Only the three remote modes may be picked, and only in the centre position.
      if (switch_pos == OMC_SW_REMOTE &&
          (req == OMC_MODE_REM_RUN || req == OMC_MODE_REM_TEST || req == OMC_MODE_REM_PROGRAM_SWITCH_POSITION)) begin
        mode_nxt = req;
      end else begin
        rej_nxt = 1'b1;
      end
    end
    if (wr_fire && awaddr_r == OMC_A_OUT_CFG) begin
      out_cfg_nxt = wval[2*OMC_NOUT-1:0];
    end
    if (wr_fire && awaddr_r == OMC_A_LOGIC_OUT) begin
      logic_out_nxt = wval[OMC_NOUT-1:0];
    end
    if (wr_fire && awaddr_r == OMC_A_NAME) begin
      name_nxt = wval;
    end
    if (act[OMC_ACT_DL_START]) begin
      if (perm_r.download_ok) begin
        dl_busy_nxt = 1'b1;
      end else begin
        dl_rej_nxt = 1'b1;
      end
    end
    if (act[OMC_ACT_DL_DONE] && dl_busy_r) begin
      dl_busy_nxt = 1'b0;
      disp_nxt = name_r;
      disp_v_nxt = 1'b1;
    end
    if (act[OMC_ACT_EDIT] && !perm_r.edit_ok) begin
      ed_rej_nxt = 1'b1;
    end
    if (act[OMC_ACT_FW] && !perm_r.fw_ok) begin
      fw_rej_nxt = 1'b1;
    end
    // A download cut short by a move to the run position is abandoned.
    if (switch_pos == OMC_SW_RUN) begin
      dl_busy_nxt = 1'b0;
    end
  end

  always_comb begin
    logic runlike, proglike;
    runlike = mode_nxt == OMC_MODE_RUN || mode_nxt == OMC_MODE_REM_RUN;
    proglike = mode_nxt == OMC_MODE_PROGRAM_SWITCH_POSITION || mode_nxt == OMC_MODE_REM_PROGRAM_SWITCH_POSITION;
    perm_nxt.out_logic = runlike;
    perm_nxt.exec_ok = runlike || mode_nxt == OMC_MODE_REM_TEST;
    perm_nxt.download_ok = mode_nxt != OMC_MODE_RUN;
    perm_nxt.fw_ok = mode_nxt != OMC_MODE_RUN;
    perm_nxt.mode_chg_ok = switch_pos == OMC_SW_REMOTE;
    perm_nxt.sched_ok = proglike;
    perm_nxt.edit_ok = mode_nxt != OMC_MODE_RUN;
    perm_nxt.partner_data = 1'b1;
  end

  // ----------------------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < OMC_NOUT; i++) begin : g_out
    always_comb begin
      if (perm_nxt.out_logic) begin
        out_nxt[i] = logic_out_nxt[i];
      end else begin
        unique case (out_cfg_r[2*i +: 2])
          OMC_OUT_ON: out_nxt[i] = 1'b1;
          OMC_OUT_HOLD: out_nxt[i] = out_r[i];
          default: out_nxt[i] = 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------------
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = OMC_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      unique case (s_axi_araddr)
        OMC_A_STATUS: begin
          rdata_nxt[OMC_ST_MODE_LSB +: 3] = mode_r;
          rdata_nxt[OMC_ST_SW_LSB +: 2] = switch_pos;
          rdata_nxt[OMC_ST_PERM_LSB +: 8] = perm_r;
          rdata_nxt[OMC_ST_REJ_BIT] = rej_r;
          rdata_nxt[OMC_ST_DL_REJ_BIT] = dl_rej_r;
          rdata_nxt[OMC_ST_ED_REJ_BIT] = ed_rej_r;
          rdata_nxt[OMC_ST_FW_REJ_BIT] = fw_rej_r;
        end
        OMC_A_MODE_REQ: rdata_nxt[2:0] = mode_r;
        OMC_A_ACTION: rdata_nxt[0] = dl_busy_r;
        OMC_A_OUT_CFG: rdata_nxt[2*OMC_NOUT-1:0] = out_cfg_r;
        OMC_A_LOGIC_OUT: rdata_nxt[OMC_NOUT-1:0] = logic_out_r;
        OMC_A_NAME: rdata_nxt = name_r;
        OMC_A_DISP: rdata_nxt = disp_r;
        OMC_A_OUTPUTS: rdata_nxt[OMC_NOUT-1:0] = out_r;
        default: rresp_nxt = OMC_RESP_SLVERR;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  // The switch is sampled on the first clock after release, so reset holds only constants.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= OMC_MODE_REM_PROGRAM_SWITCH_POSITION;
      perm_r <= '0;
      out_r <= '0;
      out_cfg_r <= '0;
      logic_out_r <= '0;
      name_r <= '0;
      disp_r <= '0;
      disp_v_r <= 1'b0;
      dl_busy_r <= 1'b0;
      rej_r <= 1'b0;
      dl_rej_r <= 1'b0;
      ed_rej_r <= 1'b0;
      fw_rej_r <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= OMC_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= OMC_RESP_OKAY;
    end else begin
      mode_r <= mode_nxt;
      perm_r <= perm_nxt;
      out_r <= out_nxt;
      out_cfg_r <= out_cfg_nxt;
      logic_out_r <= logic_out_nxt;
      name_r <= name_nxt;
      disp_r <= disp_nxt;
      disp_v_r <= disp_v_nxt;
      dl_busy_r <= dl_busy_nxt;
      rej_r <= rej_nxt;
      dl_rej_r <= dl_rej_nxt;
      ed_rej_r <= ed_rej_nxt;
      fw_rej_r <= fw_rej_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_awready = !aw_got_r;
  assign s_axi_wready = !w_got_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign mode = mode_r;
  assign perm = perm_r;
  assign out_drive = out_r;
  assign display_name = disp_r;
  assign display_valid = disp_v_r;

endmodule : omc_mode_ctrl
`default_nettype wire

/* verilog/omc_pkg.sv */
`default_nettype none
package omc_pkg;

  // ----------------------------------------------------------------------------
  // Key switch and operating modes
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    OMC_SW_RUN,
    OMC_SW_REMOTE,
    OMC_SW_PROGRAM_SWITCH_POSITION,
    OMC_SW_BAD
  } omc_switch_type;

  typedef enum logic [2:0] {
    OMC_MODE_RUN,
    OMC_MODE_REM_RUN,
    OMC_MODE_REM_TEST,
    OMC_MODE_REM_PROGRAM_SWITCH_POSITION,
    OMC_MODE_PROGRAM_SWITCH_POSITION
  } omc_mode_type;

  // Program-mode output state codes.
  localparam logic [1:0] OMC_OUT_OFF = 2'h0;
  localparam logic [1:0] OMC_OUT_ON = 2'h1;
  localparam logic [1:0] OMC_OUT_HOLD = 2'h2;

  localparam int OMC_NOUT = 8;
  localparam int OMC_NAME_W = 32;

  // ----------------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] OMC_A_STATUS = 8'h00;
  localparam logic [7:0] OMC_A_MODE_REQ = 8'h04;
  localparam logic [7:0] OMC_A_ACTION = 8'h08;
  localparam logic [7:0] OMC_A_OUT_CFG = 8'h0c;
  localparam logic [7:0] OMC_A_LOGIC_OUT = 8'h10;
  localparam logic [7:0] OMC_A_NAME = 8'h14;
  localparam logic [7:0] OMC_A_DISP = 8'h18;
  localparam logic [7:0] OMC_A_OUTPUTS = 8'h1c;

  // STATUS fields.
  localparam int OMC_ST_MODE_LSB = 0;
  localparam int OMC_ST_SW_LSB = 4;
  localparam int OMC_ST_PERM_LSB = 8;
  localparam int OMC_ST_REJ_BIT = 16;
  localparam int OMC_ST_DL_REJ_BIT = 17;
  localparam int OMC_ST_ED_REJ_BIT = 18;
  localparam int OMC_ST_FW_REJ_BIT = 19;

  // ACTION write bits: one-shot requests.
  localparam int OMC_ACT_DL_START = 0;
  localparam int OMC_ACT_DL_DONE = 1;
  localparam int OMC_ACT_EDIT = 2;
  localparam int OMC_ACT_FW = 3;
  localparam int OMC_ACT_CLR_REJ = 4;

  localparam logic [1:0] OMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] OMC_RESP_SLVERR = 2'h2;

  // Permission bundle.
  typedef struct packed {
    logic partner_data;
    logic edit_ok;
    logic sched_ok;
    logic fw_ok;
    logic mode_chg_ok;
    logic download_ok;
    logic exec_ok;
    logic out_logic;
  } omc_perm_type;

endpackage : omc_pkg
`default_nettype wire
